// [rtl/nbc_pkg.sv]
// Package of constants for the host-side NAND flash busy/bad-block controller.
// Assumes a 20 MHz system clock driving all sequencing logic.
package nbc_pkg;
    // System clock period in nanoseconds.
    localparam int CLK_NS = 50;
    // Device timing figures in their own units.
    localparam int WRITE_EDGE_TO_BUSY_DELAY_NS = 100;
    localparam int ARRAY_TO_REGISTER_TIME_US   = 25;
    localparam int CACHE_READ_BUSY_MIN_US      = 3;
    localparam int PAGE_PROGRAM_TIME_US        = 700;
    localparam int CACHE_PROGRAM_BUSY_TIME_US  = 700;
    localparam int FEATURE_ACCESS_BUSY_TIME_US = 1;
    localparam int LOCKED_BLOCK_BUSY_TIME_US   = 3;
    localparam int PROTECTED_OTP_BUSY_TIME_US  = 30;
    localparam int RESET_FIRST_BUSY_US         = 1000;
    localparam int RESET_LATER_BUSY_US         = 5;
    localparam int BLOCK_ERASE_TIME_US         = 10000;
    // Cycle counts; the write-to-busy guard rounds up, the timeouts round down.
    localparam int WB_CYC    = (WRITE_EDGE_TO_BUSY_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_CYC    = ARRAY_TO_REGISTER_TIME_US * 1000 / CLK_NS;
    localparam int CRD_CYC   = CACHE_READ_BUSY_MIN_US * 1000 / CLK_NS;
    localparam int PROG_CYC  = PAGE_PROGRAM_TIME_US * 1000 / CLK_NS;
    localparam int CPROG_CYC = CACHE_PROGRAM_BUSY_TIME_US * 1000 / CLK_NS;
    localparam int FEAT_CYC  = FEATURE_ACCESS_BUSY_TIME_US * 1000 / CLK_NS;
    localparam int LOCK_CYC  = LOCKED_BLOCK_BUSY_TIME_US * 1000 / CLK_NS;
    localparam int OTP_CYC   = PROTECTED_OTP_BUSY_TIME_US * 1000 / CLK_NS;
    localparam int RSTL_CYC  = RESET_LATER_BUSY_US * 1000 / CLK_NS;
    localparam int RST1_CYC  = RESET_FIRST_BUSY_US * 1000 / CLK_NS;
    localparam int ERS_CYC   = BLOCK_ERASE_TIME_US * 1000 / CLK_NS;
    // Device organisation and host duties.
    localparam int BLOCKS          = 1024;
    localparam int MIN_VALID       = 1004;
    localparam int PARTIAL_PROGRAM_LIMIT = 4;
    localparam int ECC_UNIT_BYTES  = 528;
    localparam logic [7:0] MARK_GOOD  = 8'hFF;
    localparam logic [7:0] CMD_RESET  = 8'hFF;
    // Operation codes of the user command port.
    typedef enum logic [2:0] {
        NBC_OP_READ, NBC_OP_CREAD, NBC_OP_PROG, NBC_OP_CPROG,
        NBC_OP_FEAT, NBC_OP_ERASE, NBC_OP_RESET, NBC_OP_OTP
    } nbc_op_t;
endpackage : nbc_pkg

// [rtl/nbc_fifo.sv]
// Synchronous FIFO in flip-flops with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps
module nbc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      cnt_ff;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // Full and empty come straight from the occupancy count.
    assign in_ready  = (cnt_ff < (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rd_ff];

    // Pointers and count advance on accepted handshakes.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
            if (pop) rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage has no reset; only written entries are ever read.
    always_ff @(posedge clk) begin
        if (push) mem_ff[wr_ff] <= in_data;
    end
endmodule : nbc_fifo

// [rtl/nbc_ctrl.sv]
// Host controller sequencing NAND operations: busy waits, bad-block table, program order.
// Assumes a byte-wide NAND whose ready/busy pin is asynchronous to clk.
// Function
// - hold off commands during write-to-busy window
// - at most four partial programs per page
// - bad blocks marked non-FFh, host builds table
// - record marks before any erase
// - check status after program and erase
// - ECC one bit per 528 bytes; no ECC logic here, only the constant
// - on failure retire and replace block; the code only marks the block bad
// - program pages in ascending order
// - first command after power-on is reset
`timescale 1ns/10ps
module nbc_ctrl
    import nbc_pkg::*;
#(
    parameter int BLK_W     = 10,
    parameter int PAGE_W    = 6,
    parameter int FIFO_DEPTH = 16,
    parameter int RST1_CYCLES = RST1_CYC,
    parameter int ERS_CYCLES  = ERS_CYC,
    parameter int PROG_CYCLES = PROG_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              cmd_valid,
    input  wire logic [2:0]        cmd_op,
    input  wire logic [BLK_W-1:0]  cmd_block,
    input  wire logic [PAGE_W-1:0] cmd_page,
    output logic                   cmd_ready,
    input  wire logic [7:0]        wr_data,
    input  wire logic              wr_valid,
    output logic                   wr_ready,
    input  wire logic              mark_valid,
    input  wire logic [7:0]        mark_byte,
    input  wire logic              status_fail,
    output logic [7:0]             nand_data_out,
    output logic                   nand_data_oe,
    output logic                   nand_cmd_strobe,
    input  wire logic              ready_busy_output,
    output logic                   done_ff,
    output logic                   fail_ff,
    output logic                   timeout_ff,
    output logic                   bad_block_ff,
    output logic                   init_done_ff
);
    // Cycles the synchroniser needs before the pin's busy level is seen; ready is not trusted before it.
    localparam int RB_SETTLE = 4;
    typedef enum logic [2:0] {NBC_IDLE, NBC_GUARD, NBC_BUSY, NBC_STATUS} nbc_state_t;
    nbc_state_t       state_ff;
    logic [2:0]       rb_sync_ff;
    logic             rb_ff;
    logic [23:0]      tmr_ff;
    logic [23:0]      lim_ff;
    logic [23:0]      min_ff;
    logic [BLOCKS-1:0] bad_ff;
    logic             first_rst_ff;
    logic             prog_seen_ff;
    logic [2:0]       nop_ff [BLOCKS];
    logic [PAGE_W-1:0] last_page_ff [BLOCKS];
    logic [BLOCKS-1:0] page_used_ff;
    nbc_op_t          op_ff;
    logic [BLK_W-1:0] blk_ff;
    logic [7:0]       fdata;
    logic             fvalid;
    wire              fpop = fvalid && (state_ff == NBC_GUARD);

    // Write data passes a FIFO; it drains during the guard state of every command, not only programs.
    nbc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_data   (wr_data),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .out_data  (fdata),
        .out_valid (fvalid),
        .out_ready (fpop)
    );

    // Command decode and checks on the requested operation.
    wire nbc_op_t req_op   = nbc_op_t'(cmd_op);
    wire is_prog    = req_op == NBC_OP_PROG || req_op == NBC_OP_CPROG;
    wire is_pe      = is_prog || req_op == NBC_OP_ERASE;
    wire page_order = !page_used_ff[cmd_block] || cmd_page >= last_page_ff[cmd_block];
    wire nop_ok     = nop_ok_f(cmd_block, cmd_page);
    wire need_rst   = first_rst_ff && req_op != NBC_OP_RESET;
    wire blocked    = is_pe && (bad_ff[cmd_block] || !init_done_ff);
    wire reject     = need_rst || blocked || (is_prog && !(page_order && nop_ok));
    wire take       = cmd_valid && cmd_ready;
    wire rb_high    = rb_sync_ff[2] && rb_sync_ff[1];
    wire busy_end   = (tmr_ff >= min_ff) && rb_ff;
    wire tmo        = tmr_ff >= lim_ff;
    wire pe_fail    = state_ff == NBC_STATUS && status_fail &&
                      (op_ff == NBC_OP_PROG || op_ff == NBC_OP_CPROG || op_ff == NBC_OP_ERASE);

    function automatic logic nop_ok_f(input logic [BLK_W-1:0] b, input logic [PAGE_W-1:0] p);
        nop_ok_f = !(page_used_ff[b] && p == last_page_ff[b]) ||
                   nop_ff[b] < 3'(PARTIAL_PROGRAM_LIMIT);
    endfunction : nop_ok_f

    // Timeout per operation; maximum busy times act only as limits.
    function automatic logic [23:0] limit_f(input nbc_op_t o, input logic fr);
        unique case (o)
            NBC_OP_READ:  limit_f = 24'(RD_CYC);
            NBC_OP_CREAD: limit_f = 24'(RD_CYC);
            NBC_OP_PROG:  limit_f = 24'(PROG_CYCLES);
            NBC_OP_CPROG: limit_f = 24'(CPROG_CYC + PROG_CYCLES);
            NBC_OP_FEAT:  limit_f = 24'(FEAT_CYC);
            NBC_OP_ERASE: limit_f = 24'(ERS_CYCLES);
            NBC_OP_RESET: limit_f = fr ? 24'(RST1_CYCLES) : 24'(RSTL_CYC);
            NBC_OP_OTP:   limit_f = 24'(OTP_CYC);
        endcase
    endfunction : limit_f

    assign cmd_ready = state_ff == NBC_IDLE;

    // Ready/busy pin passes three flip-flops; a level counts when stages 2 and 3 agree.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rb_sync_ff <= 3'h0;
            rb_ff      <= 1'b0;
        end else begin
            rb_sync_ff <= {rb_sync_ff[1:0], ready_busy_output};
            if (rb_sync_ff[2] == rb_sync_ff[1]) rb_ff <= rb_high;
        end
    end

    // Operation sequencer: guard window, busy wait, status check.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= NBC_IDLE; tmr_ff <= 24'h0; lim_ff <= 24'h0; min_ff <= 24'h0;
            op_ff <= NBC_OP_READ; blk_ff <= '0; first_rst_ff <= 1'b1;
            done_ff <= 1'b0; fail_ff <= 1'b0; timeout_ff <= 1'b0; bad_block_ff <= 1'b0;
            nand_data_out <= 8'h0; nand_data_oe <= 1'b0; nand_cmd_strobe <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            nand_cmd_strobe <= 1'b0;
            tmr_ff <= tmr_ff + 24'h1;
            unique case (state_ff)
                NBC_IDLE: if (take) begin
                    fail_ff <= reject;
                    timeout_ff <= 1'b0;
                    if (reject) done_ff <= 1'b1;
                    else begin
                        op_ff <= req_op; blk_ff <= cmd_block; tmr_ff <= 24'h0;
                        lim_ff <= limit_f(req_op, first_rst_ff);
                        min_ff <= req_op == NBC_OP_CREAD ? 24'(CRD_CYC) : 24'(WB_CYC + RB_SETTLE);
                        nand_cmd_strobe <= 1'b1;
                        nand_data_out <= req_op == NBC_OP_RESET ? CMD_RESET : {5'h0, cmd_op};
                        nand_data_oe <= 1'b1;
                        state_ff <= NBC_GUARD;
                    end
                end
                NBC_GUARD: if (!fvalid && tmr_ff >= 24'(WB_CYC)) begin
                    nand_data_oe <= 1'b0;
                    state_ff <= NBC_BUSY;
                end else if (fvalid) nand_data_out <= fdata;
                NBC_BUSY: if (busy_end || tmo) begin
                    timeout_ff <= tmo && !busy_end;
                    fail_ff <= tmo && !busy_end;
                    if (op_ff == NBC_OP_RESET) first_rst_ff <= 1'b0;
                    state_ff <= NBC_STATUS;
                end
                NBC_STATUS: begin
                    fail_ff <= status_fail || timeout_ff;
                    bad_block_ff <= pe_fail;
                    done_ff <= 1'b1;
                    state_ff <= NBC_IDLE;
                end
                default: state_ff <= NBC_IDLE;
            endcase
        end
    end

    // Bad-block table built from the scan; failed blocks are retired.
    wire [BLK_W-1:0] scan_blk = cmd_block;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bad_ff <= '0; init_done_ff <= 1'b0; page_used_ff <= '0;
        end else begin
            if (mark_valid && mark_byte != MARK_GOOD && scan_blk != '0)
                bad_ff[scan_blk] <= 1'b1;
            if (mark_valid && scan_blk == BLK_W'(BLOCKS - 1)) init_done_ff <= 1'b1;
            if (pe_fail) bad_ff[blk_ff] <= 1'b1;
            if (take && !reject && is_prog) page_used_ff[cmd_block] <= 1'b1;
            if (take && !reject && req_op == NBC_OP_ERASE) page_used_ff[cmd_block] <= 1'b0;
        end
    end

    // Per-block page order and partial program counts.
    always_ff @(posedge clk) begin
        if (take && !reject && is_prog) begin
            last_page_ff[cmd_block] <= cmd_page;
            nop_ff[cmd_block] <= (page_used_ff[cmd_block] && cmd_page == last_page_ff[cmd_block])
                                 ? nop_ff[cmd_block] + 3'h1 : 3'h1;
        end
    end
endmodule : nbc_ctrl

// [tb/nbc_ctrl_monitor.sv]
// Concurrent checks on the ports of the NAND host controller.
// Assumes one clock domain and the active-low asynchronous reset of the controller.
`timescale 1ns/10ps
module nbc_ctrl_monitor #(
    parameter int BLK_W = 10
) (
    input wire logic             clk,
    input wire logic             rst_n,
    input wire logic             cmd_valid,
    input wire logic [2:0]       cmd_op,
    input wire logic [BLK_W-1:0] cmd_block,
    input wire logic             cmd_ready,
    input wire logic             mark_valid,
    input wire logic             status_fail,
    input wire logic             nand_data_oe,
    input wire logic             nand_cmd_strobe,
    input wire logic             ready_busy_output,
    input wire logic             done_ff,
    input wire logic             fail_ff,
    input wire logic             timeout_ff,
    input wire logic             init_done_ff
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // A page program or erase request taken by the controller (cache program excluded).
    wire pe_take = cmd_valid && cmd_ready && (cmd_op == 3'h2 || cmd_op == 3'h5);
    // Scan reaching the last block.
    wire last_mark = mark_valid && (&cmd_block);
    a_strobe_guard: assert property (nand_cmd_strobe |-> !cmd_ready [*3])
        else $error("command accepted inside the write-to-busy window");
    a_strobe_drive: assert property (nand_cmd_strobe |-> nand_data_oe)
        else $error("command strobe without bus drive");
    a_unscanned_refuse: assert property (pe_take && !init_done_ff |-> ##[1:2] (done_ff && fail_ff))
        else $error("program or erase accepted before the scan");
    a_scan_ends: assert property (last_mark |-> ##[1:3] init_done_ff)
        else $error("scan of last block did not finish init");
    a_status_fails: assert property (done_ff && $past(status_fail, 1) && $past(status_fail, 2) |-> fail_ff)
        else $error("failed status not reported");
    a_ready_ends: assert property (done_ff && !fail_ff |-> $past(ready_busy_output, 2))
        else $error("busy wait ended without ready");
    a_timeout_fails: assert property (timeout_ff |-> fail_ff)
        else $error("timeout without fail");
    a_done_pulse: assert property ($rose(done_ff) |=> !done_ff)
        else $error("done longer than one cycle");
    // Main scenarios reached.
    c_pass: cover property (done_ff && !fail_ff);
    c_refuse: cover property (pe_take && !init_done_ff);
    c_timeout: cover property ($rose(timeout_ff));
endmodule : nbc_ctrl_monitor

bind nbc_ctrl nbc_ctrl_monitor #(.BLK_W(BLK_W)) i_mon (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_block(cmd_block), .cmd_ready(cmd_ready), .mark_valid(mark_valid),
    .status_fail(status_fail), .nand_data_oe(nand_data_oe), .nand_cmd_strobe(nand_cmd_strobe),
    .ready_busy_output(ready_busy_output), .done_ff(done_ff), .fail_ff(fail_ff), .timeout_ff(timeout_ff),
    .init_done_ff(init_done_ff));

// [tb/nbc_nand_model.sv]
// Behavioural NAND device answering each command strobe with a busy period.
// Assumes the bench sets the busy length before each command.
`timescale 1ns/10ps
module nbc_nand_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic cmd_strobe,
    input  wire logic [31:0] busy_len,
    output logic      ready_busy_output
);
    int cnt_ff;
    // Busy starts one cycle after the strobe and lasts the chosen time, above the limit in the timeout test.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 0;
        end else if (cmd_strobe) begin
            cnt_ff <= busy_len;
        end else if (cnt_ff != 0) begin
            cnt_ff <= cnt_ff - 1;
        end
    end
    // Ready whenever no busy period runs.
    assign ready_busy_output = (cnt_ff == 0);
endmodule : nbc_nand_model

// [tb/tb.sv]
// Self-checking bench for the NAND host controller.
// Assumes the device model in nbc_nand_model and the bound port checker.
`timescale 1ns/10ps
module tb import nbc_pkg::*;;
    logic       clk, rst_n, cmd_valid, wr_valid, mark_valid, status_fail;
    logic [2:0] cmd_op;
    logic [9:0] cmd_block;
    logic [5:0] cmd_page;
    logic [7:0] wr_data, mark_byte, nand_data_out;
    logic       cmd_ready, wr_ready, nand_data_oe, nand_cmd_strobe, ready_busy_output;
    logic       done_ff, fail_ff, timeout_ff, bad_block_ff, init_done_ff;
    int         busy_len, n_mismatch, total_checks;
    nbc_ctrl #(.RST1_CYCLES(60), .ERS_CYCLES(60), .PROG_CYCLES(60)) i_dut (.clk(clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_block(cmd_block), .cmd_page(cmd_page), .cmd_ready(cmd_ready),
        .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .mark_valid(mark_valid), .mark_byte(mark_byte),
        .status_fail(status_fail), .nand_data_out(nand_data_out), .nand_data_oe(nand_data_oe),
        .nand_cmd_strobe(nand_cmd_strobe), .ready_busy_output(ready_busy_output), .done_ff(done_ff),
        .fail_ff(fail_ff), .timeout_ff(timeout_ff), .bad_block_ff(bad_block_ff), .init_done_ff(init_done_ff));
    nbc_nand_model i_nand (.clk(clk), .rst_n(rst_n), .cmd_strobe(nand_cmd_strobe), .busy_len(busy_len),
        .ready_busy_output(ready_busy_output));
    // Free-running system clock.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task close_out;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    task chk(input string nm, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %b seen %b", nm, e, g);
            n_mismatch++;
        end
    endtask : chk
    // Issues one command, waits a bounded time for done and judges fail and timeout.
    task run(input logic [2:0] op, input logic [9:0] b, input logic [5:0] p, input int bl, input logic ef,
             input logic et);
        int i;
        @(posedge clk);
        busy_len <= bl;
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_block <= b;
        cmd_page <= p;
        i = 0;
        do begin
            @(negedge clk);
            i++;
        end while (cmd_ready !== 1'b1 && i < 100);
        if (i >= 100) begin
            $display("[ERR] cmd_ready expected 1 seen %b", cmd_ready);
            n_mismatch++;
            close_out();
        end
        @(posedge clk);
        cmd_valid <= 1'b0;
        i = 0;
        do begin
            @(negedge clk);
            i++;
        end while (done_ff !== 1'b1 && i < 4000);
        chk("done", 1'b1, done_ff);
        if (i >= 4000) begin
            close_out();
        end
        chk("fail", ef, fail_ff);
        chk("timeout", et, timeout_ff);
    endtask : run
    task t_power_up;
        run(NBC_OP_READ, 10'h000, 6'h00, 8, 1'b1, 1'b0);
        run(NBC_OP_RESET, 10'h000, 6'h00, 20, 1'b0, 1'b0);
    endtask : t_power_up
    // Blocks 0 and the top twenty carry bad marks; block 0 must still count as valid.
    task t_scan;
        run(NBC_OP_ERASE, 10'h001, 6'h00, 8, 1'b1, 1'b0);
        for (int b = 0; b < BLOCKS; b++) begin
            @(posedge clk);
            mark_valid <= 1'b1;
            cmd_block <= 10'(b);
            mark_byte <= (b == 0 || b >= MIN_VALID) ? 8'h00 : MARK_GOOD;
        end
        @(posedge clk);
        mark_valid <= 1'b0;
        repeat (3) @(negedge clk);
        chk("init_done", 1'b1, init_done_ff);
        run(NBC_OP_PROG, 10'h000, 6'h00, 8, 1'b0, 1'b0);
        run(NBC_OP_PROG, 10'h3F2, 6'h00, 8, 1'b1, 1'b0);
        chk("bad_block", 1'b0, bad_block_ff);
    endtask : t_scan
    task t_all_ops;
        for (int op = 0; op < 8; op++) begin
            run(3'(op), 10'h003, 6'(op), 8, 1'b0, 1'b0);
        end
    endtask : t_all_ops
    task t_partial;
        repeat (PARTIAL_PROGRAM_LIMIT) run(NBC_OP_PROG, 10'h004, 6'h09, 8, 1'b0, 1'b0);
        run(NBC_OP_PROG, 10'h004, 6'h09, 8, 1'b1, 1'b0);
        run(NBC_OP_PROG, 10'h004, 6'h08, 8, 1'b1, 1'b0);
        @(posedge clk);
        status_fail <= 1'b1;
        run(NBC_OP_PROG, 10'h004, 6'h0A, 8, 1'b1, 1'b0);
        chk("bad_block", 1'b1, bad_block_ff);
        @(posedge clk);
        status_fail <= 1'b0;
        run(NBC_OP_PROG, 10'h004, 6'h0B, 8, 1'b1, 1'b0);
    endtask : t_partial
    // Fills the buffer until it refuses, then a program drains it.
    task t_fifo;
        for (int i = 0; i < 17; i++) begin
            @(posedge clk);
            wr_valid <= 1'b1;
            wr_data <= 8'(i);
        end
        @(negedge clk);
        chk("wr_ready_full", 1'b0, wr_ready);
        @(posedge clk);
        wr_valid <= 1'b0;
        run(NBC_OP_PROG, 10'h006, 6'h00, 40, 1'b0, 1'b0);
        chk("wr_ready_drained", 1'b1, wr_ready);
    endtask : t_fifo
    task t_timeout;
        run(NBC_OP_READ, 10'h006, 6'h01, 100000, 1'b1, 1'b1);
        run(NBC_OP_RESET, 10'h000, 6'h00, 8, 1'b0, 1'b0);
    endtask : t_timeout
    // Main sequence.
    initial begin
        {rst_n, cmd_valid, wr_valid, mark_valid, status_fail} = 5'h00;
        {cmd_op, cmd_block, cmd_page, wr_data, mark_byte} = 35'h0;
        busy_len = 8;
        n_mismatch = 0;
        total_checks = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_power_up();
        t_scan();
        t_all_ops();
        t_partial();
        t_fifo();
        t_timeout();
        close_out();
    end
endmodule : tb
